// ### hrb_bridge.sv
`timescale 1ns/1ns
`include "hrb_regs.svh"

module hrb_bridge
    import hrb_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYC = `HRB_DEBOUNCE_MS * `HRB_MCLK_KHZ
) (
    // System
    input  wire logic        mclk,
    input  wire logic        reset,
    // Two-wire bus
    input  wire logic        scl,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Enable and buttons
    input  wire logic        hid_function_enable,
    input  wire logic        volume_raise_button_n,
    input  wire logic        volume_lower_button_n,
    input  wire logic        playback_silence_button_n,
    input  wire logic        record_silence_button_n,
    // USB HID side
    input  wire logic        hid_report_taken,
    output logic             hid_report_pend,
    output logic [23:0]      hid_report_data,
    input  wire logic        set_report_stb,
    input  wire logic [7:0]  set_report_byte
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic                      scl_m1_r;
    logic                      scl_m2_r;
    logic                      scl_m3_r;
    logic                      sda_m1_r;
    logic                      sda_m2_r;
    logic                      sda_m3_r;
    logic                      hen_m1_r;
    logic                      hen_m2_r;
    logic                      wtg_m1_r;
    logic                      wtg_m2_r;
    logic                      wtg_m3_r;
    logic                      start_det;
    logic                      stop_det;
    logic                      busy_r;
    logic                      busy_nxt;
    logic                      link_hold_r;
    logic                      link_hold_nxt;
    logic                      wr_evt_r;
    logic                      wr_evt_nxt;
    logic [7:0]                wr_even_r;
    logic [7:0]                wr_even_nxt;
    logic [7:0]                wr_odd_r;
    logic [7:0]                wr_odd_nxt;
    logic [7:0]                host_byte_r;
    logic [7:0]                host_byte_nxt;
    logic [7:0]                rd_shadow_r;
    logic [7:0]                rd_shadow_nxt;
    logic [`HRB_BTN_COUNT-1:0] btn_pin_n;
    logic [`HRB_BTN_COUNT-1:0] btn_pressed;
    logic [`HRB_BTN_COUNT-1:0] btn_chg;
    logic [7:0]                btn_status;
    hrb_link_st_t              st_r;
    hrb_link_st_t              st_nxt;
    logic [3:0]                bit_cnt_r;
    logic [3:0]                bit_cnt_nxt;
    logic [7:0]                shreg_r;
    logic [7:0]                shreg_nxt;
    logic [7:0]                tx_r;
    logic [7:0]                tx_nxt;
    logic                      ack_r;
    logic                      ack_nxt;
    logic                      ptr_r;
    logic                      ptr_nxt;
    logic [7:0]                byte_in;
    logic                      store;
    logic [7:0]                lreg_r [2];
    logic [7:0]                lreg_nxt [2];
    logic                      ltgl_r;
    logic                      ltgl_nxt;
    logic                      oe_r;
    logic                      oe_nxt;
    logic                      sdo_r;

    // ------------------------------------------------------------------------
    // Pin synchronisers and START / STOP detection on mclk
    // ------------------------------------------------------------------------
    assign start_det = scl_m2_r & scl_m3_r & sda_m3_r & ~sda_m2_r;
    assign stop_det  = scl_m2_r & scl_m3_r & ~sda_m3_r & sda_m2_r;

    // The link engine is held in reset while the bus is idle and from a
    // START until SCL is seen low, so every frame starts from the address.
    always_comb begin
        busy_nxt      = busy_r;
        link_hold_nxt = link_hold_r;
        if (stop_det) begin
            busy_nxt      = 1'b0;
            link_hold_nxt = 1'b1;
        end else if (start_det) begin
            busy_nxt      = 1'b1;
            link_hold_nxt = 1'b1;
        end else if (busy_r && !scl_m2_r) begin
            link_hold_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            scl_m1_r    <= 1'b1;
            scl_m2_r    <= 1'b1;
            scl_m3_r    <= 1'b1;
            sda_m1_r    <= 1'b1;
            sda_m2_r    <= 1'b1;
            sda_m3_r    <= 1'b1;
            hen_m1_r    <= 1'b0;
            hen_m2_r    <= 1'b0;
            busy_r      <= 1'b0;
            link_hold_r <= 1'b1;
        end else begin
            scl_m1_r    <= scl;
            scl_m2_r    <= scl_m1_r;
            scl_m3_r    <= scl_m2_r;
            sda_m1_r    <= sda_i;
            sda_m2_r    <= sda_m1_r;
            sda_m3_r    <= sda_m2_r;
            hen_m1_r    <= hid_function_enable;
            hen_m2_r    <= hen_m1_r;
            busy_r      <= busy_nxt;
            link_hold_r <= link_hold_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Crossings between mclk and the link
    // ------------------------------------------------------------------------
    // Written bytes are stable for many SCL periods after the toggle flips,
    // so they are copied on mclk once the toggle has been synchronised.
    // The read shadow only changes while the bus is idle, so the link side
    // always sees a settled byte.
    always_comb begin
        wr_evt_nxt    = wtg_m2_r ^ wtg_m3_r;
        wr_even_nxt   = wr_evt_nxt ? lreg_r[0] : wr_even_r;
        wr_odd_nxt    = wr_evt_nxt ? lreg_r[1] : wr_odd_r;
        host_byte_nxt = host_byte_r;
        if (set_report_stb && hen_m2_r) begin
            host_byte_nxt = set_report_byte;
        end
        rd_shadow_nxt = busy_r ? rd_shadow_r : host_byte_r;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wtg_m1_r    <= 1'b0;
            wtg_m2_r    <= 1'b0;
            wtg_m3_r    <= 1'b0;
            wr_evt_r    <= 1'b0;
            wr_even_r   <= `HRB_BYTE_RST;
            wr_odd_r    <= `HRB_BYTE_RST;
            host_byte_r <= `HRB_BYTE_RST;
            rd_shadow_r <= `HRB_BYTE_RST;
        end else begin
            wtg_m1_r    <= ltgl_r;
            wtg_m2_r    <= wtg_m1_r;
            wtg_m3_r    <= wtg_m2_r;
            wr_evt_r    <= wr_evt_nxt;
            wr_even_r   <= wr_even_nxt;
            wr_odd_r    <= wr_odd_nxt;
            host_byte_r <= host_byte_nxt;
            rd_shadow_r <= rd_shadow_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Link engine, sampled on the rising SCL edge
    // ------------------------------------------------------------------------
    assign byte_in = {shreg_r[6:0], sda_i};

    always_comb begin
        st_nxt      = st_r;
        bit_cnt_nxt = bit_cnt_r;
        shreg_nxt   = shreg_r;
        tx_nxt      = tx_r;
        ack_nxt     = ack_r;
        ptr_nxt     = ptr_r;
        store       = 1'b0;
        if (bit_cnt_r == `HRB_ACK_SLOT) begin
            bit_cnt_nxt = 4'h0;
            ack_nxt     = 1'b0;
            if (st_r == st_read) begin
                if (sda_i) begin
                    st_nxt = st_ignore;
                end else begin
                    tx_nxt = rd_shadow_r;
                end
            end
        end else begin
            shreg_nxt   = byte_in;
            bit_cnt_nxt = bit_cnt_r + 4'h1;
            if (st_r == st_read) begin
                tx_nxt = {tx_r[6:0], 1'b0};
            end
            if (bit_cnt_r == `HRB_LAST_BIT) begin
                unique case (st_r)
                    st_addr: begin
                        if (byte_in[7:1] == `HRB_SLAVE_ADDR) begin
                            ack_nxt = 1'b1;
                            st_nxt  = (byte_in[0] == `HRB_DIR_READ) ? st_read : st_rega;
                        end else begin
                            st_nxt = st_ignore;
                        end
                    end
                    st_rega: begin
                        ptr_nxt = byte_in[0];
                        ack_nxt = 1'b1;
                        st_nxt  = st_data;
                    end
                    st_data: begin
                        store   = 1'b1;
                        ptr_nxt = ~ptr_r;
                        ack_nxt = 1'b1;
                    end
                    st_read, st_ignore: ack_nxt = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge scl or posedge link_hold_r) begin
        if (link_hold_r) begin
            st_r      <= st_addr;
            bit_cnt_r <= 4'h0;
            shreg_r   <= `HRB_BYTE_RST;
            tx_r      <= `HRB_BYTE_RST;
            ack_r     <= 1'b0;
            ptr_r     <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shreg_r   <= shreg_nxt;
            tx_r      <= tx_nxt;
            ack_r     <= ack_nxt;
            ptr_r     <= ptr_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Write registers on the link clock, kept across frames
    // ------------------------------------------------------------------------
    always_comb begin
        lreg_nxt    = lreg_r;
        ltgl_nxt    = ltgl_r;
        if (store) begin
            lreg_nxt[ptr_r] = byte_in;
            ltgl_nxt        = ~ltgl_r;
        end
    end

    always_ff @(posedge scl or posedge reset) begin
        if (reset) begin
            lreg_r    <= '{default: `HRB_BYTE_RST};
            ltgl_r    <= 1'b0;
        end else begin
            lreg_r    <= lreg_nxt;
            ltgl_r    <= ltgl_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Open-drain data driver, updated on the falling SCL edge
    // ------------------------------------------------------------------------
    always_comb begin
        oe_nxt = (bit_cnt_r == `HRB_ACK_SLOT) ? ack_r : ((st_r == st_read) && !tx_r[7]);
    end

    always_ff @(negedge scl or posedge link_hold_r) begin
        if (link_hold_r) begin
            oe_r  <= 1'b0;
            sdo_r <= 1'b0;
        end else begin
            oe_r  <= oe_nxt;
            sdo_r <= 1'b0;
        end
    end

    assign sda_oe = oe_r;
    assign sda_o  = sdo_r;

    // ------------------------------------------------------------------------
    // Buttons
    // ------------------------------------------------------------------------
    assign btn_pin_n[`HRB_BTN_RAISE] = volume_raise_button_n;
    assign btn_pin_n[`HRB_BTN_LOWER] = volume_lower_button_n;
    assign btn_pin_n[`HRB_BTN_PLAY]  = playback_silence_button_n;
    assign btn_pin_n[`HRB_BTN_REC]   = record_silence_button_n;
    assign btn_status = {{(8 - `HRB_BTN_COUNT){1'b0}}, btn_pressed};

    for (genvar i = 0; i < `HRB_BTN_COUNT; i++) begin : g_btn
        hrb_debounce #(.CYC(DEBOUNCE_CYC)) u_deb (
            .mclk(mclk), .reset(reset), .pin_n(btn_pin_n[i]), .pressed(btn_pressed[i]), .changed(btn_chg[i])
        );
    end

    // ------------------------------------------------------------------------
    // Upward report
    // ------------------------------------------------------------------------
    hrb_report u_rpt (
        .mclk(mclk), .reset(reset), .hid_en(hen_m2_r), .btn_changed(|btn_chg), .btn_status(btn_status),
        .wr_evt(wr_evt_r), .wr_even(wr_even_r), .wr_odd(wr_odd_r),
        .taken(hid_report_taken), .pend(hid_report_pend), .data(hid_report_data)
    );

endmodule : hrb_bridge

// ### hrb_regs.svh
`ifndef HRB_REGS_SVH
`define HRB_REGS_SVH

// ----------------------------------------------------------------------------
// Two-wire slave constants
// ----------------------------------------------------------------------------
`define HRB_SLAVE_ADDR   7'h38
`define HRB_LAST_BIT     4'h7
`define HRB_ACK_SLOT     4'h8
`define HRB_DIR_READ     1'b1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define HRB_MCLK_KHZ     125000
`define HRB_DEBOUNCE_MS  64

// ----------------------------------------------------------------------------
// Button status byte layout and reset values
// ----------------------------------------------------------------------------
`define HRB_BTN_COUNT    4
`define HRB_BTN_RAISE    0
`define HRB_BTN_LOWER    1
`define HRB_BTN_PLAY     2
`define HRB_BTN_REC      3
`define HRB_BYTE_RST     8'h00
`define HRB_RPT_RST      24'h000000

`endif

// ### hrb_pkg.sv
package hrb_pkg;

    // ------------------------------------------------------------------------
    // Link engine states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        st_addr,
        st_rega,
        st_data,
        st_read,
        st_ignore
    } hrb_link_st_t;

endpackage : hrb_pkg

// ### hrb_debounce.sv
`timescale 1ns/1ns
`include "hrb_regs.svh"

module hrb_debounce #(
    parameter int unsigned CYC = `HRB_DEBOUNCE_MS * `HRB_MCLK_KHZ
) (
    // System
    input  wire logic mclk,
    input  wire logic reset,
    // Button pin, low while pressed
    input  wire logic pin_n,
    // Debounced result
    output logic      pressed,
    output logic      changed
);

    localparam int CW = $clog2(CYC + 1);

    logic          sync1_r;
    logic          sync2_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          pressed_r;
    logic          pressed_nxt;
    logic          changed_r;
    logic          changed_nxt;

    // ------------------------------------------------------------------------
    // A change is accepted only after it has held for the full window.
    // ------------------------------------------------------------------------
    always_comb begin
        cnt_nxt     = '0;
        pressed_nxt = pressed_r;
        changed_nxt = 1'b0;
        if (~sync2_r != pressed_r) begin
            if (cnt_r == CW'(CYC - 1)) begin
                pressed_nxt = ~sync2_r;
                changed_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + CW'(1);
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sync1_r   <= 1'b1;
            sync2_r   <= 1'b1;
            cnt_r     <= '0;
            pressed_r <= 1'b0;
            changed_r <= 1'b0;
        end else begin
            sync1_r   <= pin_n;
            sync2_r   <= sync1_r;
            cnt_r     <= cnt_nxt;
            pressed_r <= pressed_nxt;
            changed_r <= changed_nxt;
        end
    end

    assign pressed = pressed_r;
    assign changed = changed_r;

endmodule : hrb_debounce

// ### hrb_report.sv
`timescale 1ns/1ns
`include "hrb_regs.svh"

module hrb_report (
    // System
    input  wire logic        mclk,
    input  wire logic        reset,
    // Sources
    input  wire logic        hid_en,
    input  wire logic        btn_changed,
    input  wire logic [7:0]  btn_status,
    input  wire logic        wr_evt,
    input  wire logic [7:0]  wr_even,
    input  wire logic [7:0]  wr_odd,
    // USB interrupt pipe side
    input  wire logic        taken,
    output logic             pend,
    output logic [23:0]      data
);

    logic        pend_r;
    logic        pend_nxt;
    logic [23:0] data_r;
    logic [23:0] data_nxt;
    logic        evt;

    // ------------------------------------------------------------------------
    // A new event wins over a take in the same cycle so it is not lost.
    // ------------------------------------------------------------------------
    always_comb begin
        evt      = btn_changed | wr_evt;
        data_nxt = {wr_odd, wr_even, btn_status};
        pend_nxt = pend_r;
        if (!hid_en) begin
            pend_nxt = 1'b0;
        end else if (evt) begin
            pend_nxt = 1'b1;
        end else if (taken) begin
            pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pend_r <= 1'b0;
            data_r <= `HRB_RPT_RST;
        end else begin
            pend_r <= pend_nxt;
            data_r <= data_nxt;
        end
    end

    assign pend = pend_r;
    assign data = data_r;

endmodule : hrb_report

// ### hrb_bridge_checker.sv
`timescale 1ns/1ns

module hrb_bridge_checker #(
    parameter int unsigned DEBOUNCE_CYC = 20
) (
    // System
    input wire logic        mclk,
    input wire logic        reset,
    // Two-wire bus
    input wire logic        scl,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe,
    // Enable and buttons
    input wire logic        hid_function_enable,
    input wire logic        volume_raise_button_n,
    input wire logic        volume_lower_button_n,
    input wire logic        playback_silence_button_n,
    input wire logic        record_silence_button_n,
    // USB HID side
    input wire logic        hid_report_taken,
    input wire logic        hid_report_pend,
    input wire logic [23:0] hid_report_data,
    input wire logic        set_report_stb,
    input wire logic [7:0]  set_report_byte
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------------------
    // Cycles the raise button has been held pressed
    // ------------------------------------------------------------------------
    int unsigned held_r;
    int unsigned held_nxt;

    always_comb begin
        held_nxt = held_r;
        if (volume_raise_button_n) begin
            held_nxt = 0;
        end else if (held_r < 32'h0000FFFF) begin
            held_nxt = held_r + 1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            held_r <= 0;
        end else begin
            held_r <= held_nxt;
        end
    end

    AST_SDA_OPEN_DRAIN: assert property (sda_o == 1'b0)
        else $error("data output value not zero");
    AST_DRIVE_ON_LOW_CLOCK: assert property ($rose(sda_oe) |-> !scl)
        else $error("data drive began while clock high");
    AST_RESET_IDLE: assert property ($fell(reset) |-> !hid_report_pend && hid_report_data == 24'h000000)
        else $error("report outputs not idle after reset");
    AST_PEND_STANDS: assert property (hid_report_pend && !hid_report_taken && hid_function_enable
        && $past(hid_function_enable, 2) |=> hid_report_pend)
        else $error("pending report dropped without take");
    AST_NO_PEND_DISABLED: assert property ((!hid_function_enable) [*4] |-> !hid_report_pend)
        else $error("report pending while disabled");
    AST_DATA_WITH_PEND: assert property (hid_function_enable && $past(hid_function_enable)
        && $past(hid_function_enable, 2) && $past(hid_function_enable, 3) && !$stable(hid_report_data)
        |-> hid_report_pend)
        else $error("report data changed without pending flag");
    AST_STATUS_HIGH_ZERO: assert property (hid_report_data[7:4] == 4'h0)
        else $error("unused status bits not zero");
    AST_DEBOUNCE_HELD: assert property ($rose(hid_report_data[0]) |-> held_r >= DEBOUNCE_CYC)
        else $error("button reported before debounce time");
    AST_PEND_NEEDS_ENABLE: assert property ($rose(hid_report_pend) |-> $past(hid_function_enable, 3))
        else $error("report raised while disabled");
endmodule : hrb_bridge_checker

bind hrb_bridge hrb_bridge_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_chk (
    .mclk(mclk), .reset(reset), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .hid_function_enable(hid_function_enable), .volume_raise_button_n(volume_raise_button_n),
    .volume_lower_button_n(volume_lower_button_n), .playback_silence_button_n(playback_silence_button_n),
    .record_silence_button_n(record_silence_button_n), .hid_report_taken(hid_report_taken),
    .hid_report_pend(hid_report_pend), .hid_report_data(hid_report_data),
    .set_report_stb(set_report_stb), .set_report_byte(set_report_byte)
);

// ### hrb_twowire_master.sv
`timescale 1ns/1ns

module hrb_twowire_master (
    // Bus
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    // The clock stands high and the data line is released between frames.
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    // One bit of 30 ns: data set while the clock is low, sampled while high.
    task automatic bitx(input logic v, output logic s);
        #7 sda_oe = ~v;
        #8 scl = 1'b1;
        #5 s = sda;
        #10 scl = 1'b0;
    endtask : bitx

    task automatic start;
        sda_oe = 1'b1;
        #600 scl = 1'b0;
        #1400;
    endtask : start

    // Repeated START: release data while the clock is low, raise the clock, then start again.
    task automatic rstart;
        #7 sda_oe = 1'b0;
        #8 scl = 1'b1;
        #600;
        start();
    endtask : rstart

    task automatic stop;
        #7 sda_oe = 1'b1;
        #8 scl = 1'b1;
        #600 sda_oe = 1'b0;
        #600;
    endtask : stop

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int j = 7; j >= 0; j--) begin
            bitx(b[j], s);
        end
        bitx(1'b1, ack);
    endtask : wbyte

    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        for (int j = 7; j >= 0; j--) begin
            bitx(1'b1, b[j]);
        end
        bitx(last, s);
    endtask : rbyte
endmodule : hrb_twowire_master

// ### hrb_bridge_test.sv
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module hrb_bridge_test;
    localparam int unsigned DB = 20;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        hid_en = 1'b1;
    logic [3:0]  btn_n = 4'hF;
    logic        taken = 1'b0;
    logic        stb = 1'b0;
    logic [7:0]  sbyte = 8'h00;
    logic        scl;
    logic        m_oe;
    logic        sda_o;
    logic        sda_oe;
    wire         sda_w = ~(sda_oe | m_oe);
    logic        pend;
    logic [23:0] data;
    logic        pend_q = 1'b0;
    logic [23:0] e_r;
    logic [7:0]  st = 8'h00;
    logic [7:0]  ev = 8'h00;
    logic [7:0]  od = 8'h00;
    logic [31:0] r;
    logic [23:0] exp_q[$];
    int          err_count = 0;
    int          samples_checked = 0;

    always #4 mclk = ~mclk;

    hrb_bridge #(.DEBOUNCE_CYC(DB)) dut (
        .mclk(mclk), .reset(reset), .scl(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .hid_function_enable(hid_en), .volume_raise_button_n(btn_n[0]), .volume_lower_button_n(btn_n[1]),
        .playback_silence_button_n(btn_n[2]), .record_silence_button_n(btn_n[3]),
        .hid_report_taken(taken), .hid_report_pend(pend), .hid_report_data(data),
        .set_report_stb(stb), .set_report_byte(sbyte)
    );
    hrb_twowire_master mst (.scl(scl), .sda_oe(m_oe), .sda(sda_w));

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic finish_test;
        if (err_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic drain(input int n);
        for (int i = 0; i < n && exp_q.size() > 0; i++) tick(1);
        if (exp_q.size() > 0) begin
            err_count++;
            $display("[ERR] %0t report missing", $time);
            finish_test;
        end
    endtask : drain

    task automatic take;
        @(posedge mclk) taken <= 1'b1;
        @(posedge mclk) taken <= 1'b0;
        tick(2);
    endtask : take

    task automatic set_rpt(input logic [7:0] b);
        @(posedge mclk) stb <= 1'b1;
        sbyte <= b;
        @(posedge mclk) stb <= 1'b0;
    endtask : set_rpt

    task automatic wr(input logic [7:0] a, input logic [7:0] ra, input logic [7:0] d0, input logic [7:0] d1);
        logic k;
        mst.start();
        mst.wbyte(a, k);
        `CHK(k, a != 8'h70)
        if (a == 8'h70) begin
            mst.wbyte(ra, k);
            `CHK(k, 1'b0)
            if (ra[0]) od = d0;
            else ev = d0;
            if (hid_en) exp_q.push_back({od, ev, st});
            mst.wbyte(d0, k);
            `CHK(k, 1'b0)
            if (ra[0]) ev = d1;
            else od = d1;
            mst.wbyte(d1, k);
            `CHK(k, 1'b0)
        end
        mst.stop();
        if (hid_en) begin
            drain(40);
            `CHK(data, {od, ev, st})
            take();
        end
    endtask : wr

    task automatic rd(input logic [7:0] e);
        logic       k;
        logic [7:0] b;
        mst.start();
        mst.wbyte(8'h70, k);
        `CHK(k, 1'b0)
        mst.rstart();
        mst.wbyte(8'h71, k);
        `CHK(k, 1'b0)
        mst.rbyte(1'b0, b);
        `CHK(b, e)
        mst.rbyte(1'b1, b);
        `CHK(b, e)
        mst.stop();
    endtask : rd

    task automatic press(input int i, input logic v);
        st[i] = ~v;
        exp_q.push_back({od, ev, st});
        @(posedge mclk) btn_n[i] <= v;
        drain(DB + 40);
        take();
    endtask : press

    // ------------------------------------------------------------------------
    // Each new report is compared with the oldest noted expectation
    // ------------------------------------------------------------------------
    always @(posedge mclk) begin
        pend_q <= pend;
        if (pend === 1'b1 && pend_q === 1'b0) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("[ERR] %0t report not expected", $time);
            end else begin
                e_r = exp_q.pop_front();
                `CHK(data, e_r)
            end
        end
    end

    initial begin
        r = $urandom(61);
        tick(6);
        reset <= 1'b0;
        tick(8);
        `CHK(pend, 1'b0)
        `CHK(data, 24'h000000)
        `CHK(sda_oe, 1'b0)
        `CHK(sda_o, 1'b0)
        wr(8'h70, r[7:0] & 8'hFE, r[15:8], r[23:16]);
        wr(8'h70, 8'hFF, 8'h5A, 8'hC3);
        wr(8'h72, 8'h00, 8'h11, 8'h22);
        set_rpt(r[31:24]);
        tick(4);
        rd(r[31:24]);
        set_rpt(8'h3C);
        set_rpt(8'hC3);
        tick(4);
        rd(8'hC3);
        hid_en <= 1'b0;
        tick(4);
        set_rpt(8'h96);
        wr(8'h70, 8'h00, 8'h44, 8'h66);
        tick(40);
        rd(8'hC3);
        hid_en <= 1'b1;
        tick(4);
        btn_n[0] <= 1'b0;
        tick(DB / 2);
        btn_n[0] <= 1'b1;
        tick(DB + 10);
        for (int k = 0; k < 4; k++) begin
            press((r[1:0] + k) % 4, 1'b0);
            press((r[1:0] + k) % 4, 1'b1);
        end
        finish_test;
    end
endmodule : hrb_bridge_test
